// *** core/elc_edge_det.sv ***
// Edge detector: compares each line with its previous sample.
// Assumes inputs are already synchronous to clk_sys_i.
`timescale 1ns/10ps
module elc_edge_det #(
    parameter int W = 1
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic [W-1:0] level_i,
    output logic [W-1:0] rise_o,
    output logic [W-1:0] fall_o
);

    logic primed_q;    // Set once a first sample is held
    genvar b;

    ////////////////////////////////////////////////////////////////////////////
    // Primed flag: no edge is reported against the reset value of the sample,
    // so a line that is high after reset does not fake a rising edge
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            primed_q <= 1'b0;
        else
            primed_q <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-line previous sample and edge terms
    generate
        for (b = 0; b < W; b++)
        begin : g_line
            logic prev_q;  // Last cycle's level
            always_ff @(posedge clk_sys_i or posedge sys_rst_i)
            begin
                if (sys_rst_i)
                    prev_q <= 1'b0;
                else
                    prev_q <= level_i[b];
            end
            assign rise_o[b] = primed_q & level_i[b] & ~prev_q;
            assign fall_o[b] = primed_q & ~level_i[b] & prev_q;
        end
    endgenerate

endmodule

// *** core/elc_line_ctrl.sv ***
// External line interrupt and event controller, top level.
// Assumes a classic Wishbone master on clk_sys_i, pins and internal sources
// asynchronous, and core-side status inputs synchronous to clk_sys_i.
//
// Summary of operation
// (RULE1) Interrupt mask bit 0 blocks line request.
// (RULE2) Event mask bit 0 suppresses line event pulse.
// (RULE3) Both mask registers reset to zero.
// (RULE4) Lines 0-15 follow same-index pin, selected port.
// (RULE5) Lines 16-18: supply monitor, alarm, USB wake.
// (RULE6) Wake on interrupt or event per wait kind.
// (RULE7) Event wake raises no interrupt request.
// (RULE8) Event-mode line leaves its pending flag clear.
// (RULE9) Send-event-on-pending turns masked pending into event.
// (RULE10) Software clears both pending flags after such wake.
// (RULE11) Independent edge enables; edges ignored during edge enable writes.
// (RULE12) Edge sets pending; write-one or polarity change clears.
// (RULE13) Synchronise, then compare with previous sample.
`timescale 1ns/10ps
module elc_line_ctrl (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire elc_pkg::elc_wb_req_s wb_req_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [elc_pkg::ELC_NPORT-1:0][elc_pkg::ELC_NPIN-1:0] gpio_port_i,
    input wire elc_pkg::elc_src_s src_i,
    input wire logic send_event_on_pending_i,
    input wire logic periph_pend_masked_i,
    input wire logic core_wait_for_interrupt_i,
    input wire logic core_wait_for_event_i,
    output logic [elc_pkg::ELC_NLINE-1:0] line_irq_o,
    output logic [elc_pkg::ELC_NLINE-1:0] line_event_o,
    output logic core_event_o,
    output logic core_wake_o,
    output logic irq_o
);
    import elc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    elc_line_t imask_q;            // line_interrupt_mask
    elc_line_t emask_q;            // line_event_mask
    elc_line_t rise_en_q;          // rising_edge_enable
    elc_line_t fall_en_q;          // falling_edge_enable
    elc_line_t swtrig_q;           // software_trigger
    elc_line_t pend_q;             // line_pending_flags
    logic [31:0] psel_q;           // Port select, two bits per pin line
    logic [ELC_NSTAT-1:0] stat_q;  // Sticky block status
    logic [ELC_NSTAT-1:0] sten_q;  // Status interrupt enable
    logic ack_q;                   // Bus acknowledge
    logic [31:0] rdat_q;           // Read data held with ack
    elc_line_t line_irq_q;         // Requests toward the core controller
    elc_line_t line_event_q;       // Per-line event pulses
    logic core_event_q;            // Wake-from-event pulse
    logic core_wake_q;             // Wake level to the core
    logic irq_q;                   // Block interrupt
    logic ppm_prev_q;              // Last periph pending-masked level

    // Bus decode
    logic acc;                     // Request active
    logic wr;                      // Write takes effect this edge
    logic [31:0] wmask;            // Byte lanes as bit mask
    logic [31:0] wval;             // Masked write data
    logic wr_imask, wr_emask, wr_rise, wr_fall, wr_sw, wr_pend;
    logic wr_psel, wr_stclr, wr_sten;
    logic [31:0] rmux;             // Read data before the flop

    // Line path
    logic [ELC_NPORT*ELC_NPIN-1:0] pins_s;   // Synchronised pins
    logic [2:0] src_s;                        // Synchronised internal sources
    elc_line_t line_lvl;           // Selected line levels
    elc_line_t rise, fall;         // Edges this cycle
    elc_line_t rise_new, fall_new; // Edge enables after a write
    elc_line_t pol_chg;            // Lines whose polarity changes
    logic edge_block;              // Edge enable write in progress
    elc_line_t trig;               // Hardware triggers
    elc_line_t sw_set;             // Software triggers, 0 to 1 only
    elc_line_t line_hit;           // Any trigger on a line
    elc_line_t pend_set, pend_clr;
    logic sev_hit;                 // Masked peripheral went pending

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode; a write acts on the edge that also sees ack high
    assign acc = wb_req_i.cyc & wb_req_i.stb;
    assign wr = acc & wb_req_i.we & ack_q;
    assign wmask = {{8{wb_req_i.sel[3]}}, {8{wb_req_i.sel[2]}},
                    {8{wb_req_i.sel[1]}}, {8{wb_req_i.sel[0]}}};
    assign wval = wb_req_i.dat & wmask;
    assign wr_imask = wr & (wb_req_i.adr == ELC_OFF_IMASK);
    assign wr_emask = wr & (wb_req_i.adr == ELC_OFF_EMASK);
    assign wr_rise = wr & (wb_req_i.adr == ELC_OFF_RISE);
    assign wr_fall = wr & (wb_req_i.adr == ELC_OFF_FALL);
    assign wr_sw = wr & (wb_req_i.adr == ELC_OFF_SWTRIG);
    assign wr_pend = wr & (wb_req_i.adr == ELC_OFF_PEND);
    assign wr_psel = wr & (wb_req_i.adr == ELC_OFF_PSEL);
    assign wr_stclr = wr & (wb_req_i.adr == ELC_OFF_STCLR);
    assign wr_sten = wr & (wb_req_i.adr == ELC_OFF_STEN);

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers and edge detection
    elc_sync2 #(
        .W(ELC_NPORT*ELC_NPIN + 3)
    ) u_sync (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .async_i({src_i, gpio_port_i}),
        .sync_o({src_s, pins_s})
    ); // [RULE13]

    // Pin lines pick the same-index pin of their selected port
    genvar li;
    generate
        for (li = 0; li < ELC_NPIN; li++)
        begin : g_pinline
            logic [ELC_PSEL_W-1:0] sel;
            assign sel = psel_q[li*ELC_PSEL_W +: ELC_PSEL_W];
            assign line_lvl[li] = pins_s[32'(sel)*ELC_NPIN + li]; // [RULE4]
        end
    endgenerate

    // Internal sources on the upper lines; lines 19..31 do not exist
    assign line_lvl[ELC_LINE_SUPPLY] = src_s[0]; // [RULE5]
    assign line_lvl[ELC_LINE_ALARM] = src_s[1]; // [RULE5]
    assign line_lvl[ELC_LINE_USB] = src_s[2]; // [RULE5]

    elc_edge_det #(
        .W(ELC_NLINE)
    ) u_edge (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .level_i(line_lvl),
        .rise_o(rise),
        .fall_o(fall)
    ); // [RULE13]

    ////////////////////////////////////////////////////////////////////////////
    // Trigger logic
    // Edge enables after a pending write, and which lines change polarity
    assign rise_new = wr_rise ? ((rise_en_q & ~wmask[18:0]) | wval[18:0]) : rise_en_q;
    assign fall_new = wr_fall ? ((fall_en_q & ~wmask[18:0]) | wval[18:0]) : fall_en_q;
    assign pol_chg = (rise_new ^ rise_en_q) | (fall_new ^ fall_en_q); // [RULE12]
    // Edges that meet a write to either enable register are dropped;
    // coarse per register, which keeps the path short
    assign edge_block = wr_rise | wr_fall; // [RULE11]
    // Both enables may be on together
    assign trig = ((rise & rise_en_q) | (fall & fall_en_q))
                  & ~{ELC_NLINE{edge_block}}; // [RULE11]
    // Software trigger only acts where the bit goes from 0 to 1
    assign sw_set = wr_sw ? (wval[18:0] & ~swtrig_q) : ELC_LINE_RST;
    assign line_hit = trig | sw_set;
    // Only interrupt-mode lines pend; event-only lines leave no flag
    assign pend_set = line_hit & imask_q; // [RULE8]
    assign pend_clr = (wr_pend ? wval[18:0] : ELC_LINE_RST) | pol_chg; // [RULE12]
    assign sev_hit = send_event_on_pending_i & periph_pend_masked_i & ~ppm_prev_q;

    ////////////////////////////////////////////////////////////////////////////
    // Mask registers
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            imask_q <= ELC_LINE_RST; // [RULE3]
            emask_q <= ELC_LINE_RST; // [RULE3]
        end
        else
        begin
            if (wr_imask)
                imask_q <= (imask_q & ~wmask[18:0]) | wval[18:0];
            if (wr_emask)
                emask_q <= (emask_q & ~wmask[18:0]) | wval[18:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Edge enables and port select
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            rise_en_q <= ELC_LINE_RST;
            fall_en_q <= ELC_LINE_RST;
            psel_q <= ELC_PSEL_RST;
        end
        else
        begin
            rise_en_q <= rise_new; // [RULE11]
            fall_en_q <= fall_new; // [RULE11]
            if (wr_psel)
                psel_q <= (psel_q & ~wmask) | wval;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software trigger and pending flags; a set in the clear cycle wins
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            swtrig_q <= ELC_LINE_RST;
            pend_q <= ELC_LINE_RST;
        end
        else
        begin
            swtrig_q <= (swtrig_q & ~pend_clr) | sw_set;
            pend_q <= (pend_q & ~pend_clr) | pend_set; // [RULE12]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs toward the core
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            line_irq_q <= ELC_LINE_RST;
            line_event_q <= ELC_LINE_RST;
            core_event_q <= 1'b0;
            core_wake_q <= 1'b0;
            ppm_prev_q <= 1'b0;
        end
        else
        begin
            // Pending flags reach the core only through open masks
            line_irq_q <= pend_q & imask_q; // [RULE1]
            // Event pulses carry no pending flag, hence no handler runs
            line_event_q <= line_hit & emask_q; // [RULE2] [RULE7]
            // A masked peripheral going pending is an event when enabled
            core_event_q <= (|(line_hit & emask_q)) | sev_hit; // [RULE9]
            // Wait-for-interrupt wakes on any request; wait-for-event on events
            core_wake_q <= (core_wait_for_interrupt_i & (|line_irq_q))
                         | (core_wait_for_event_i & core_event_q); // [RULE6]
            ppm_prev_q <= periph_pend_masked_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Block status, clear and enable; set wins over clear
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            stat_q <= ELC_STAT_RST;
            sten_q <= ELC_STAT_RST;
            irq_q <= 1'b0;
        end
        else
        begin
            stat_q[ELC_ST_PEND] <= (stat_q[ELC_ST_PEND] & ~(wr_stclr & wval[ELC_ST_PEND]))
                                 | (|pend_set);
            stat_q[ELC_ST_EVENT] <= (stat_q[ELC_ST_EVENT]
                                  & ~(wr_stclr & wval[ELC_ST_EVENT]))
                                  | (|(line_hit & emask_q));
            stat_q[ELC_ST_SEV] <= (stat_q[ELC_ST_SEV] & ~(wr_stclr & wval[ELC_ST_SEV]))
                                | sev_hit;
            if (wr_sten)
                sten_q <= (sten_q & ~wmask[2:0]) | wval[2:0];
            irq_q <= |(stat_q & sten_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux; unmapped and write-only offsets read as zero
    always_comb
    begin
        rmux = 32'h00000000;
        unique case (wb_req_i.adr)
            ELC_OFF_IMASK: rmux = {13'h0000, imask_q};
            ELC_OFF_EMASK: rmux = {13'h0000, emask_q};
            ELC_OFF_RISE: rmux = {13'h0000, rise_en_q};
            ELC_OFF_FALL: rmux = {13'h0000, fall_en_q};
            ELC_OFF_SWTRIG: rmux = {13'h0000, swtrig_q};
            ELC_OFF_PEND: rmux = {13'h0000, pend_q};
            ELC_OFF_PSEL: rmux = psel_q;
            ELC_OFF_STAT: rmux = {29'h00000000, stat_q};
            ELC_OFF_STEN: rmux = {29'h00000000, sten_q};
            default: rmux = 32'h00000000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Acknowledge one cycle after the request, drop it the next cycle
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            ack_q <= 1'b0;
            rdat_q <= 32'h00000000;
        end
        else
        begin
            ack_q <= acc & ~ack_q;
            if (acc & ~ack_q)
                rdat_q <= rmux;
        end
    end

    assign wb_dat_o = rdat_q;
    assign wb_ack_o = ack_q;
    assign line_irq_o = line_irq_q;
    assign line_event_o = line_event_q;
    assign core_event_o = core_event_q;
    assign core_wake_o = core_wake_q;
    assign irq_o = irq_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (sys_rst_i);

    property p_irq_masked;
        (line_irq_o & ~$past(imask_q)) == ELC_LINE_RST;
    endproperty
    a_irq_masked: assert property (p_irq_masked) // [RULE1]
        else $error("line request passed a closed interrupt mask");

    property p_event_masked;
        (line_event_o & ~$past(emask_q)) == ELC_LINE_RST;
    endproperty
    a_event_masked: assert property (p_event_masked) // [RULE2]
        else $error("event pulse passed a closed event mask");

    property p_mask_reset;
        $fell(sys_rst_i) |-> (imask_q == ELC_LINE_RST) && (emask_q == ELC_LINE_RST);
    endproperty
    a_mask_reset: assert property (p_mask_reset) // [RULE3]
        else $error("masks not zero after reset");

    property p_wfi_wake;
        core_wait_for_interrupt_i && (|line_irq_o) |=> core_wake_o;
    endproperty
    a_wfi_wake: assert property (p_wfi_wake) // [RULE6]
        else $error("no wake for pending request in wait-for-interrupt");

    property p_event_no_pend;
        (pend_q & ~$past(pend_q) & ~$past(imask_q)) == ELC_LINE_RST;
    endproperty
    a_event_no_pend: assert property (p_event_no_pend) // [RULE8]
        else $error("pending set on a line with interrupt mask closed");

    property p_sev;
        send_event_on_pending_i && periph_pend_masked_i && !ppm_prev_q |=> core_event_o;
    endproperty
    a_sev: assert property (p_sev) // [RULE9]
        else $error("send-event-on-pending gave no event");

    property p_write_blocks_edge;
        edge_block |=> (pend_q & ~$past(pend_q)) == ELC_LINE_RST;
    endproperty
    a_write_blocks_edge: assert property (p_write_blocks_edge) // [RULE11]
        else $error("edge recognised during edge enable write");

    property p_pend_clear;
        wr_pend && (line_hit == ELC_LINE_RST) |=> (pend_q & $past(wval[18:0])) == ELC_LINE_RST;
    endproperty
    a_pend_clear: assert property (p_pend_clear) // [RULE12]
        else $error("write one did not clear pending flag");

    property p_edge_pends;
        (|(rise & rise_en_q & imask_q)) && !edge_block |=> |pend_q ##1 |line_irq_o;
    endproperty
    a_edge_pends: assert property (p_edge_pends) // [RULE12]
        else $error("enabled rising edge did not pend and request");

    property p_ack_once;
        acc && !ack_q |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once)
        else $error("bus ack not a single cycle after request");

endmodule

// *** core/elc_pkg.sv ***
// Shared constants and carrier types for the external line interrupt/event controller.
// Assumes a single 25 MHz system clock and a classic Wishbone register bus.
package elc_pkg;

    // Line counts and widths
    localparam int ELC_NLINE = 19;          // Lines in use, 0..18
    localparam int ELC_NPIN = 16;           // Pin-driven lines, 0..15
    localparam int ELC_NPORT = 4;           // Pin ports that can feed a line
    localparam int ELC_PSEL_W = 2;          // Port select field width per line
    localparam int ELC_NSTAT = 3;           // Block status event bits

    // Line indices of the internal sources
    localparam int ELC_LINE_SUPPLY = 16;    // Supply monitor output
    localparam int ELC_LINE_ALARM = 17;     // Real-time clock alarm
    localparam int ELC_LINE_USB = 18;       // USB wake-up

    // Register byte offsets
    localparam logic [7:0] ELC_OFF_IMASK = 8'h00;
    localparam logic [7:0] ELC_OFF_EMASK = 8'h04;
    localparam logic [7:0] ELC_OFF_RISE = 8'h08;
    localparam logic [7:0] ELC_OFF_FALL = 8'h0c;
    localparam logic [7:0] ELC_OFF_SWTRIG = 8'h10;
    localparam logic [7:0] ELC_OFF_PEND = 8'h14;
    localparam logic [7:0] ELC_OFF_PSEL = 8'h18;
    localparam logic [7:0] ELC_OFF_STAT = 8'h20;
    localparam logic [7:0] ELC_OFF_STCLR = 8'h24;
    localparam logic [7:0] ELC_OFF_STEN = 8'h28;

    // Values after reset
    localparam logic [18:0] ELC_LINE_RST = 19'h00000;
    localparam logic [31:0] ELC_PSEL_RST = 32'h00000000;
    localparam logic [2:0] ELC_STAT_RST = 3'h0;

    // Status bit positions
    localparam int ELC_ST_PEND = 0;         // A line pending flag was set
    localparam int ELC_ST_EVENT = 1;        // An event pulse went to the core
    localparam int ELC_ST_SEV = 2;          // Send-event-on-pending event raised

    // One bit per line
    typedef logic [ELC_NLINE-1:0] elc_line_t;

    // Classic Wishbone request from the master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } elc_wb_req_s;

    // Internal line sources, unsynchronised
    typedef struct packed {
        logic usb_wakeup;
        logic rtc_alarm;
        logic supply_monitor_output;
    } elc_src_s;

endpackage

// *** core/elc_sync2.sv ***
// Two-flop synchroniser for a vector of asynchronous levels.
// Assumes each bit is an independent level; no word coherence is given.
`timescale 1ns/10ps
module elc_sync2 #(
    parameter int W = 1
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Per-bit two-flop chain; first stage is read only by the second
    genvar b;
    generate
        for (b = 0; b < W; b++)
        begin : g_bit
            logic meta_q;      // First stage, may go metastable
            logic stab_q;      // Second stage, safe to use
            always_ff @(posedge clk_sys_i or posedge sys_rst_i)
            begin
                if (sys_rst_i)
                begin
                    meta_q <= 1'b0;
                    stab_q <= 1'b0;
                end
                else
                begin
                    meta_q <= async_i[b];
                    stab_q <= meta_q;
                end
            end
            assign sync_o[b] = stab_q;
        end
    endgenerate

endmodule

// *** sim/elc_core_model.sv ***
// Behavioural model of the processor core that stands behind the controller.
// Assumes the bench asks it to halt and to raise a peripheral pending flag.
`timescale 1ns/10ps
module elc_core_model (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic sleep_i, // Halt request, one cycle
    input wire logic kind_i, // 1: wait for event, 0: wait for interrupt
    input wire logic pend_set_i, // A disabled peripheral request appears
    input wire logic core_wake_i,
    output logic wfi_o,
    output logic wfe_o,
    output logic pend_o
);
    ////////////////////////////////////////////////////////////////////
    // Halt state: leaves either wait kind as soon as a wake arrives
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            wfi_o <= 1'b0;
            wfe_o <= 1'b0;
        end
        else if (core_wake_i)
        begin
            wfi_o <= 1'b0;
            wfe_o <= 1'b0;
        end
        else if (sleep_i)
        begin
            wfi_o <= !kind_i;
            wfe_o <= kind_i;
        end
    end

    // Peripheral pending flag; software clears it after the wake
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            pend_o <= 1'b0;
        else if (pend_set_i)
            pend_o <= 1'b1;
        else if (core_wake_i && wfe_o)
            pend_o <= 1'b0;
    end
endmodule

// *** sim/elc_line_ctrl_test.sv ***
// Self-checking bench for the line interrupt/event controller.
// Assumes the core model file is compiled first.
`timescale 1ns/10ps
module elc_line_ctrl_test;
    import elc_pkg::*;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    elc_wb_req_s req = '0;
    logic [31:0] rd;
    logic wb_ack_o;
    logic [31:0] wb_dat_o;
    logic [ELC_NPORT-1:0][ELC_NPIN-1:0] gpio = '0;
    elc_src_s src = '0;
    logic sev_en = 1'b0, sleep = 1'b0, kind = 1'b0, pset = 1'b0;
    logic wait_for_interrupt, wait_for_event, ppend, clr = 1'b0;
    elc_line_t line_irq_o, line_event_o, seen_ev;
    logic core_event_o, core_wake_o, irq_o, seen_wake, seen_cev;
    int err_total = 0, checks = 0, cyc = 0;

    always #20 clk_sys_i = !clk_sys_i; // 25 MHz

    elc_line_ctrl uut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .wb_req_i(req),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .gpio_port_i(gpio), .src_i(src),
        .send_event_on_pending_i(sev_en), .periph_pend_masked_i(ppend),
        .core_wait_for_interrupt_i(wait_for_interrupt), .core_wait_for_event_i(wait_for_event),
        .line_irq_o(line_irq_o), .line_event_o(line_event_o),
        .core_event_o(core_event_o), .core_wake_o(core_wake_o), .irq_o(irq_o));
    elc_core_model core (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .sleep_i(sleep),
        .kind_i(kind), .pend_set_i(pset), .core_wake_i(core_wake_o), .wfi_o(wait_for_interrupt),
        .wfe_o(wait_for_event), .pend_o(ppend));

    ////////////////////////////////////////////////////////////////////
    // Sticky capture of one-cycle pulses, so checks need no exact cycle
    always @(posedge clk_sys_i)
    begin
        seen_ev <= clr ? '0 : seen_ev | line_event_o;
        seen_wake <= clr ? 1'b0 : seen_wake | core_wake_o;
        seen_cev <= clr ? 1'b0 : seen_cev | core_event_o;
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            err_total++;
            stop_test();
        end
    end

    task automatic stop_test();
        if (err_total == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Classic Wishbone cycle; holds the request until ack is sampled,
    // only the bench timeout ends a wait that never sees ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i) req <= '{1'b1, 1'b1, w, a, 4'hf, d};
        do
            @(posedge clk_sys_i);
        while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        req <= '0;
    endtask

    task automatic wait_clr(input int n);
        @(posedge clk_sys_i) clr <= 1'b1;
        @(posedge clk_sys_i) clr <= 1'b0;
        repeat (n) @(posedge clk_sys_i);
    endtask

    task automatic pulse_sleep(input logic k);
        @(posedge clk_sys_i) sleep <= 1'b1;
        kind <= k;
        @(posedge clk_sys_i) sleep <= 1'b0;
    endtask

    // Reset values, reserved bits and an unmapped offset
    task automatic t_regs();
        wb(0, ELC_OFF_IMASK, 0);
        chk("imask rst", rd, 32'h0);
        wb(0, ELC_OFF_EMASK, 0);
        chk("emask rst", rd, 32'h0);
        wb(1, ELC_OFF_EMASK, 32'hffffffff);
        wb(0, ELC_OFF_EMASK, 0);
        chk("emask rsvd", rd, 32'h0007ffff);
        wb(0, 8'h3c, 0);
        chk("unmapped", rd, 32'h0);
        wb(1, ELC_OFF_EMASK, 32'h00020000);
    endtask

    // Pin line on port 2 only, interrupt wake, pending clear
    task automatic t_pin();
        wb(1, ELC_OFF_PSEL, 32'h00000080);
        wb(1, ELC_OFF_RISE, 32'h00030008);
        wb(1, ELC_OFF_IMASK, 32'h00000008);
        wb(1, ELC_OFF_STEN, 32'h1);
        gpio[0][3] <= 1'b1;
        wait_clr(8);
        chk("other port", line_irq_o, '0);
        pulse_sleep(1'b0);
        gpio[2][3] <= 1'b1;
        repeat (8) @(posedge clk_sys_i);
        chk("irq line3", line_irq_o, 19'h8);
        chk("wfi wake", seen_wake, 1'b1);
        chk("irq out", irq_o, 1'b1);
        wb(0, ELC_OFF_PEND, 0);
        chk("pend set", rd, 32'h8);
        wb(1, ELC_OFF_PEND, 32'h8);
        wb(1, ELC_OFF_STCLR, 32'h1);
        repeat (3) @(posedge clk_sys_i);
        chk("pend clr", line_irq_o, '0);
        chk("irq clr", irq_o, 1'b0);
    endtask

    // Event-only alarm line wakes a waiting core; masked supply line stays quiet
    task automatic t_event();
        pulse_sleep(1'b1);
        wait_clr(0);
        src.rtc_alarm <= 1'b1;
        src.supply_monitor_output <= 1'b1;
        repeat (8) @(posedge clk_sys_i);
        chk("event pulse", seen_ev, 19'h20000);
        chk("wfe wake", seen_wake, 1'b1);
        chk("no request", line_irq_o, '0);
        wb(0, ELC_OFF_PEND, 0);
        chk("no pending", rd, 32'h0);
    endtask

    // Disabled peripheral request with send-event-on-pending set
    task automatic t_sev();
        sev_en <= 1'b1;
        pulse_sleep(1'b1);
        wait_clr(0);
        @(posedge clk_sys_i) pset <= 1'b1;
        @(posedge clk_sys_i) pset <= 1'b0;
        repeat (6) @(posedge clk_sys_i);
        chk("sev event", seen_cev, 1'b1);
        chk("sev wake", seen_wake, 1'b1);
    endtask

    // USB line falling edge, polarity clear, software trigger, edge lost in a write
    task automatic t_edge();
        wb(1, ELC_OFF_IMASK, 32'h00040008);
        wb(1, ELC_OFF_FALL, 32'h00040000);
        src.usb_wakeup <= 1'b1;
        repeat (6) @(posedge clk_sys_i);
        chk("rise off", line_irq_o, '0);
        src.usb_wakeup <= 1'b0;
        repeat (6) @(posedge clk_sys_i);
        chk("fall line18", line_irq_o, 19'h40000);
        wb(1, ELC_OFF_FALL, 32'h0);
        repeat (3) @(posedge clk_sys_i);
        chk("pol clr", line_irq_o, '0);
        wb(1, ELC_OFF_SWTRIG, 32'h8);
        repeat (3) @(posedge clk_sys_i);
        chk("sw trig", line_irq_o, 19'h8);
        wb(1, ELC_OFF_PEND, 32'h8);
        gpio[2][3] <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        // Synced rise lands on the ack edge of the enable write
        gpio[2][3] <= 1'b1;
        wb(1, ELC_OFF_RISE, 32'h00030008);
        wb(0, ELC_OFF_PEND, 0);
        chk("edge in write", rd, 32'h0);
    endtask

    initial
    begin
        repeat (3) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        t_regs();
        t_pin();
        t_event();
        t_sev();
        t_edge();
        stop_test();
    end
endmodule
